// file: verilog/secl_pkg.sv
package secl_pkg;
	// Core clock and SMBus rate; one SMBus bit is four prescaler quarters
	localparam int unsigned SECL_PCLK_HZ = 25_000_000;
	localparam int unsigned SECL_SMB_HZ = 100_000;
	// Rounded up so the bus never runs above its nominal rate
	localparam logic [15:0] SECL_PRESC_RST =
		16'((SECL_PCLK_HZ + 4 * SECL_SMB_HZ - 1) / (4 * SECL_SMB_HZ));
	// Serial memory slave address and memory limits
	localparam logic [6:0] SECL_EE_SADDR = 7'h50;
	localparam logic [15:0] SECL_EE_LAST = 16'hFFFF;
	localparam logic [7:0] SECL_CSUM_OK = 8'hFF;
	localparam logic [4:0] SECL_ARB_MAX = 5'h10;
	// Strap codes that include loading, one bit per code
	localparam logic [7:0] SECL_MODE_EE_MASK = 8'h03;
	// Register byte offsets
	localparam logic [7:0] SECL_OFF_CTRL = 8'h00;
	localparam logic [7:0] SECL_OFF_STAT = 8'h04;
	localparam logic [7:0] SECL_OFF_SWITCH_CONTROL_REG = 8'h08;
	localparam logic [7:0] SECL_OFF_EEADDR = 8'h0C;
	// Field positions
	localparam int SECL_CTL_IGN_BIT = 16;
	localparam int SECL_STA_BUSY_BIT = 8;
	localparam int SECL_SWC_HALT_BIT = 0;
	localparam int SECL_EEA_MODE_LSB = 16;
	// Block type codes
	localparam logic [1:0] SECL_BT_SINGLE = 2'h0;
	localparam logic [1:0] SECL_BT_SEQ = 2'h1;
	localparam logic [1:0] SECL_BT_BAD = 2'h2;
	localparam logic [1:0] SECL_BT_DONE = 2'h3;
	// Bus transaction phases and block parser states
	typedef enum logic [2:0] {
		SECL_TS_IDLE, SECL_TS_START, SECL_TS_TXB, SECL_TS_RSTART,
		SECL_TS_RXB, SECL_TS_STOP, SECL_TS_GAP
	} secl_txn_t;
	typedef enum logic [2:0] {
		SECL_PS_B0, SECL_PS_B1, SECL_PS_CNT0, SECL_PS_CNT1, SECL_PS_DATA
	} secl_parse_t;
	// Sticky status flags, done in bit 0
	typedef struct packed {
		logic unmapped;
		logic arb_loss;
		logic nack;
		logic csum;
		logic done;
	} secl_flags_t;
	// Doubleword register write toward the configuration space
	typedef struct packed {
		logic en;
		logic [15:0] addr;
		logic [31:0] data;
	} secl_cfg_wr_t;
endpackage

// file: verilog/secl_loader.sv
// Overview of operation
// - Load only after fundamental or hot reset, when the strap mode includes loading.
// - Address the serial memory at seven-bit slave address 1010000b.
// - Prescaler resets to the value giving a 100 kHz bus clock.
// - Block address is a doubleword address; byte address appends two zeros.
// - Read from byte zero onward; stop after done block or address rollover.
// - Every register write is a full 32-bit doubleword.
// - Single block: address low, type plus address high, four data bytes LSB first.
// - Type 0 writes exactly one doubleword.
// - Sequential block count gives 1 to 65535 following data doublewords.
// - Type 1 is a sequential block.
// - Sequential data go to consecutive doubleword addresses from the start.
// - Writes to undefined registers are dropped and flag an unmapped write.
// - Type 3 is the done block: checksum then type.
// - Running 8-bit sum must end at 0xFF unless checksum ignore is set.
// - Errors abort and set reset halt; done flag set on any ending.
// - Type 2 and address rollover report as checksum errors.
// - NACK sets the nack flag; 16 lost arbitrations set arbitration loss.
//
// Decided for this implementation: register access over APB and the placing of the registers.
module secl_loader
	import secl_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Reset sequencing and mode strap
	input wire logic hot_reset_req,
	input wire logic [2:0] switch_mode_select,
	// Master SMBus pins, open drain
	input wire logic smb_clk_in,
	output logic smb_clk_out,
	output logic smb_clk_oe,
	input wire logic smb_dat_in,
	output logic smb_dat_out,
	output logic smb_dat_oe,
	// Configuration register write port
	output secl_cfg_wr_t cfg_wr,
	input wire logic cfg_unmapped,
	// Load status
	output logic load_done_flag,
	output logic reset_halt_flag,
	output logic load_busy
);
	logic [2:0] mode_s1_r, mode_s2_r;
	logic scl_s1_r, scl_s_r, sda_s1_r, sda_s_r;
	logic [1:0] settle_r;
	logic [15:0] presc_r, presc_nxt;
	logic ign_r, ign_nxt, pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt, rd_val;
	logic rd_hit, wr_acc;
	secl_txn_t txn_r, txn_nxt;
	secl_parse_t ps_r, ps_nxt;
	logic [15:0] qcnt_r, qcnt_nxt, ee_r, ee_nxt, cnt_r, cnt_nxt, reload;
	logic [1:0] q_r, q_nxt, tidx_r, tidx_nxt, db_r, db_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt, b0_r, b0_nxt, sum_r, sum_nxt, sum_b;
	logic ack_r, ack_nxt, scl_lo_r, scl_lo_nxt, sda_lo_r, sda_lo_nxt;
	logic [4:0] arb_r, arb_nxt;
	logic run_r, run_nxt, fin_r, fin_nxt, pend_r, pend_nxt, halt_r, halt_nxt;
	logic [13:0] dwa_r, dwa_nxt;
	logic [31:0] dat_r, dat_nxt;
	secl_flags_t flg_r, flg_nxt;
	secl_cfg_wr_t wr_r, wr_nxt;
	logic tick, bit_end, byte_ev, mode_ok, nack_ev, arb_ev, done_ev, cs_ev;

	// Line levels for one quarter of a phase: {clock low, data low}
	function automatic logic [1:0] drv(secl_txn_t t, logic [3:0] b, logic [1:0] q, logic s7);
		logic edge_lo;
		edge_lo = (q == 2'd0) || (q == 2'd3);
		case (t)
			SECL_TS_START, SECL_TS_RSTART: drv = {edge_lo, q[1]};
			SECL_TS_STOP: drv = {q == 2'd0, ~q[1]};
			SECL_TS_TXB: drv = {edge_lo, (b < 4'd8) & ~s7};
			SECL_TS_RXB: drv = {edge_lo, 1'b0};
			default: drv = 2'b00;
		endcase
	endfunction

	// Pin synchronisers; strap and bus lines are asynchronous
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_s1_r <= '0;
			mode_s2_r <= '0;
			{scl_s1_r, scl_s_r, sda_s1_r, sda_s_r} <= 4'hF;
			settle_r <= '0;
		end else begin
			mode_s1_r <= switch_mode_select;
			mode_s2_r <= mode_s1_r;
			{scl_s1_r, scl_s_r} <= {smb_clk_in, scl_s1_r};
			{sda_s1_r, sda_s_r} <= {smb_dat_in, sda_s1_r};
			settle_r <= {settle_r[0], 1'b1};
		end
	end

	// APB decode; one wait state keeps read data registered
	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		case (paddr)
			SECL_OFF_CTRL: begin
				rd_val[15:0] = presc_r;
				rd_val[SECL_CTL_IGN_BIT] = ign_r;
			end
			SECL_OFF_STAT: begin
				rd_val[4:0] = flg_r;
				rd_val[SECL_STA_BUSY_BIT] = run_r;
			end
			SECL_OFF_SWITCH_CONTROL_REG: rd_val[SECL_SWC_HALT_BIT] = halt_r;
			SECL_OFF_EEADDR: begin
				rd_val[15:0] = ee_r;
				rd_val[SECL_EEA_MODE_LSB +: 3] = mode_s2_r;
			end
			default: rd_hit = 1'b0;
		endcase
		pready_nxt = psel & penable & ~pready_r;
		pslverr_nxt = pready_nxt & ~rd_hit;
		prdata_nxt = pready_nxt ? rd_val : prdata_r;
		wr_acc = psel & penable & pready_r & pwrite & rd_hit;
		presc_nxt = presc_r;
		ign_nxt = ign_r;
		if (wr_acc && paddr == SECL_OFF_CTRL) begin
			presc_nxt = pwdata[15:0];
			ign_nxt = pwdata[SECL_CTL_IGN_BIT];
		end
	end

	// APB registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_r <= SECL_PRESC_RST;
			ign_r <= 1'b0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else begin
			presc_r <= presc_nxt;
			ign_r <= ign_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// Loader: bit timing, byte transactions and block parsing
	always_comb begin
		// Enum state copied on its own; a packed concatenation would strip its type
		txn_nxt = txn_r;
		ps_nxt = ps_r;
		{qcnt_nxt, q_nxt, bit_nxt, sh_nxt} = {qcnt_r, q_r, bit_r, sh_r};
		{tidx_nxt, ack_nxt, arb_nxt, ee_nxt, run_nxt, fin_nxt} = {tidx_r, ack_r, arb_r, ee_r, run_r, fin_r};
		{b0_nxt, sum_nxt, dwa_nxt, cnt_nxt, dat_nxt, db_nxt} = {b0_r, sum_r, dwa_r, cnt_r, dat_r, db_r};
		{nack_ev, arb_ev, done_ev, cs_ev, byte_ev} = 5'h0;
		wr_nxt = wr_r;
		wr_nxt.en = 1'b0;
		pend_nxt = pend_r;
		// Software clears by writing ones; hardware sets below win
		flg_nxt = flg_r;
		halt_nxt = halt_r;
		if (wr_acc && paddr == SECL_OFF_STAT)
			flg_nxt = flg_r & ~secl_flags_t'(pwdata[4:0]);
		if (wr_acc && paddr == SECL_OFF_SWITCH_CONTROL_REG)
			halt_nxt = halt_r & ~pwdata[SECL_SWC_HALT_BIT];
		sum_b = sum_r + sh_r;
		mode_ok = SECL_MODE_EE_MASK[mode_s2_r];
		reload = (presc_r == '0) ? '0 : presc_r - 16'd1;
		// Start only when the strap selects loading
		if (!run_r && pend_r && settle_r[1]) begin
			pend_nxt = 1'b0;
			if (mode_ok) begin
				// Read from byte zero with a clean sum
				{run_nxt, fin_nxt} = 2'b10;
				txn_nxt = SECL_TS_START;
				ps_nxt = SECL_PS_B0;
				{q_nxt, qcnt_nxt, ee_nxt, sum_nxt, arb_nxt} = {2'd0, reload, 16'h0000, 8'h00, 5'h00};
				flg_nxt.done = 1'b0;
			end
		end
		// Quarter timer; a released clock held low by the slave stretches it
		tick = run_r && (qcnt_r == '0) && (scl_lo_r || scl_s_r);
		bit_end = tick && (q_r == 2'd3);
		if (tick) begin
			q_nxt = q_r + 2'd1;
			qcnt_nxt = reload;
		end else if (run_r && qcnt_r != '0) begin
			qcnt_nxt = qcnt_r - 16'd1;
		end
		// Sample data at the end of the clock high time
		if (tick && q_r == 2'd2) begin
			if (txn_r == SECL_TS_RXB && bit_r < 4'd8)
				sh_nxt = {sh_r[6:0], sda_s_r};
			if (txn_r == SECL_TS_TXB && bit_r == 4'd8)
				ack_nxt = sda_s_r;
			arb_ev = (txn_r == SECL_TS_TXB) && (bit_r < 4'd8) && sh_r[7] && !sda_s_r;
		end
		if (arb_ev) begin
			// Sixteen straight losses abort, else retry the byte
			if (arb_r + 5'd1 == SECL_ARB_MAX) begin
				{flg_nxt.arb_loss, flg_nxt.done, halt_nxt, run_nxt} = 4'hE;
				txn_nxt = SECL_TS_IDLE;
			end else begin
				arb_nxt = arb_r + 5'd1;
				txn_nxt = SECL_TS_GAP;
			end
			q_nxt = 2'd0;
		end else if (bit_end) begin
			case (txn_r)
				SECL_TS_START: begin
					// Address byte for the dummy write of the memory address
					txn_nxt = SECL_TS_TXB;
					{bit_nxt, tidx_nxt} = {4'd0, 2'd0};
					sh_nxt = {SECL_EE_SADDR, 1'b0};
				end
				SECL_TS_RSTART: begin
					txn_nxt = SECL_TS_TXB;
					{bit_nxt, tidx_nxt} = {4'd0, 2'd3};
					sh_nxt = {SECL_EE_SADDR, 1'b1};
				end
				SECL_TS_TXB: begin
					if (bit_r != 4'd8) begin
						bit_nxt = bit_r + 4'd1;
						sh_nxt = {sh_r[6:0], 1'b0};
					end else if (ack_r) begin
						// Unexpected NACK ends the load with a stop
						nack_ev = 1'b1;
						{flg_nxt.nack, halt_nxt, fin_nxt} = 3'h7;
						txn_nxt = SECL_TS_STOP;
					end else begin
						bit_nxt = 4'd0;
						tidx_nxt = tidx_r + 2'd1;
						case (tidx_r)
							2'd0: sh_nxt = ee_r[15:8];
							2'd1: sh_nxt = ee_r[7:0];
							2'd2: txn_nxt = SECL_TS_RSTART;
							default: txn_nxt = SECL_TS_RXB;
						endcase
					end
				end
				SECL_TS_RXB: begin
					bit_nxt = bit_r + 4'd1;
					if (bit_r == 4'd8) begin
						byte_ev = 1'b1;
						txn_nxt = SECL_TS_STOP;
					end
				end
				SECL_TS_STOP: begin
					if (fin_r) begin
						{run_nxt, flg_nxt.done} = 2'b01;
						txn_nxt = SECL_TS_IDLE;
					end else begin
						txn_nxt = SECL_TS_GAP;
					end
				end
				SECL_TS_GAP: txn_nxt = SECL_TS_START;
				default: txn_nxt = SECL_TS_IDLE;
			endcase
		end
		// Block parser, one byte per completed read
		if (byte_ev) begin
			// Running sum over every byte read
			sum_nxt = sum_b;
			ee_nxt = ee_r + 16'd1;
			arb_nxt = '0;
			case (ps_r)
				SECL_PS_B0: begin
					b0_nxt = sh_r;
					ps_nxt = SECL_PS_B1;
				end
				SECL_PS_B1: begin
					dwa_nxt = {sh_r[5:0], b0_r};
					{db_nxt, cnt_nxt} = {2'd0, 16'd1};
					case (sh_r[7:6])
						SECL_BT_SINGLE: ps_nxt = SECL_PS_DATA;
						// Sequential block reads its count next
						SECL_BT_SEQ: ps_nxt = SECL_PS_CNT0;
						SECL_BT_DONE: begin
							// Type taken from the second byte's top bits
							{done_ev, fin_nxt} = 2'b11;
							ps_nxt = SECL_PS_B0;
							// Final sum must be all ones
							cs_ev = (sum_b != SECL_CSUM_OK) && !ign_r;
						end
						default: {cs_ev, fin_nxt} = 2'b11;
					endcase
				end
				SECL_PS_CNT0: begin
					ps_nxt = SECL_PS_CNT1;
					cnt_nxt = {8'h00, sh_r};
				end
				SECL_PS_CNT1: begin
					cnt_nxt = {sh_r, cnt_r[7:0]};
					ps_nxt = ({sh_r, cnt_r[7:0]} == 16'h0000) ? SECL_PS_B0 : SECL_PS_DATA;
				end
				default: begin
					// Data bytes assemble least significant first
					dat_nxt = {sh_r, dat_r[31:8]};
					db_nxt = db_r + 2'd1;
					if (db_r == 2'd3) begin
						wr_nxt = '{en: 1'b1, addr: {dwa_r, 2'b00}, data: {sh_r, dat_r[31:8]}};
						dwa_nxt = dwa_r + 14'd1;
						cnt_nxt = cnt_r - 16'd1;
						if (cnt_r == 16'd1)
							ps_nxt = SECL_PS_B0;
					end
				end
			endcase
			// Running past the last address is an error
			if (ee_r == SECL_EE_LAST && !done_ev)
				{cs_ev, fin_nxt} = 2'b11;
		end
		if (cs_ev)
			{flg_nxt.csum, halt_nxt} = 2'b11;
		// Unmapped target drops the write and flags it
		if (wr_r.en && cfg_unmapped)
			flg_nxt.unmapped = 1'b1;
		if (hot_reset_req)
			pend_nxt = 1'b1;
		{scl_lo_nxt, sda_lo_nxt} = run_nxt ? drv(txn_nxt, bit_nxt, q_nxt, sh_nxt[7]) : 2'b00;
	end

	// Loader registers; a load is pending straight out of reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txn_r <= SECL_TS_IDLE;
			ps_r <= SECL_PS_B0;
			{qcnt_r, q_r, bit_r, sh_r, tidx_r, ack_r, arb_r, ee_r} <= '0;
			{run_r, fin_r, pend_r, halt_r, scl_lo_r, sda_lo_r} <= 6'h08;
			{b0_r, sum_r, dwa_r, cnt_r, dat_r, db_r} <= '0;
			flg_r <= '0;
			wr_r <= '0;
			{smb_clk_out, smb_dat_out} <= 2'b11;
		end else begin
			txn_r <= txn_nxt;
			ps_r <= ps_nxt;
			{qcnt_r, q_r, bit_r, sh_r, tidx_r} <= {qcnt_nxt, q_nxt, bit_nxt, sh_nxt, tidx_nxt};
			{ack_r, arb_r, ee_r} <= {ack_nxt, arb_nxt, ee_nxt};
			{run_r, fin_r, pend_r, halt_r} <= {run_nxt, fin_nxt, pend_nxt, halt_nxt};
			{scl_lo_r, sda_lo_r} <= {scl_lo_nxt, sda_lo_nxt};
			{b0_r, sum_r, dwa_r} <= {b0_nxt, sum_nxt, dwa_nxt};
			{cnt_r, dat_r, db_r} <= {cnt_nxt, dat_nxt, db_nxt};
			flg_r <= flg_nxt;
			wr_r <= wr_nxt;
			// Released lines show high so the wire resolves from the enable alone
			{smb_clk_out, smb_dat_out} <= {~scl_lo_nxt, ~sda_lo_nxt};
		end
	end

	// Outputs are register bits
	assign {prdata, pready, pslverr} = {prdata_r, pready_r, pslverr_r};
	assign {smb_clk_oe, smb_dat_oe} = {scl_lo_r, sda_lo_r};
	assign cfg_wr = wr_r;
	assign {load_done_flag, reset_halt_flag, load_busy} = {flg_r.done, halt_r, run_r};

	// Checker helpers: boot marker and the previous write of a block
	logic chk_first_r, chk_cont_r;
	logic [15:0] chk_prev_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{chk_first_r, chk_cont_r, chk_prev_r} <= {2'b10, 16'h0000};
		end else begin
			chk_first_r <= 1'b0;
			if (wr_r.en)
				{chk_cont_r, chk_prev_r} <= {ps_r == SECL_PS_DATA, wr_r.addr};
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_abort;
		flg_r.csum && halt_r && fin_r;
	endsequence
	sequence s_type(logic [1:0] t);
		byte_ev && ps_r == SECL_PS_B1 && sh_r[7:6] == t;
	endsequence
	chk_start_mode: assert property ($rose(run_r) |-> $past(mode_ok) && $past(pend_r))
		else $error("load started without a loading mode");
	chk_slave_addr: assert property ((bit_end && txn_r == SECL_TS_START) |=>
		txn_r == SECL_TS_TXB && sh_r == {SECL_EE_SADDR, 1'b0}) else $error("bad slave address");
	chk_presc_boot: assert property (chk_first_r |-> presc_r == SECL_PRESC_RST)
		else $error("prescaler not at bus rate after reset");
	chk_dword_write: assert property (wr_r.en |-> wr_r.addr[1:0] == 2'b00
		&& wr_r.addr[15:2] == $past(dwa_r)) else $error("write not doubleword aligned");
	chk_rollover_end: assert property ((byte_ev && ee_r == SECL_EE_LAST && !done_ev) |=>
		s_abort) else $error("rollover not reported");
	chk_single_once: assert property (s_type(SECL_BT_SINGLE) |=>
		ps_r == SECL_PS_DATA && cnt_r == 16'd1) else $error("single block miscount");
	chk_seq_count: assert property (s_type(SECL_BT_SEQ) |=> ps_r == SECL_PS_CNT0)
		else $error("sequential block not decoded");
	chk_seq_incr: assert property ((wr_r.en && chk_cont_r) |->
		wr_r.addr == chk_prev_r + 16'd4) else $error("sequential address not consecutive");
	chk_unmapped_flag: assert property ((wr_r.en && cfg_unmapped) |=> flg_r.unmapped)
		else $error("unmapped write not flagged");
	chk_csum_fail: assert property (s_type(SECL_BT_DONE) ##0
		(sum_b != SECL_CSUM_OK && !ign_r) |=> s_abort) else $error("checksum mismatch missed");
	chk_done_flag: assert property ($fell(run_r) |-> flg_r.done)
		else $error("load ended without done flag");
	chk_bad_type: assert property (s_type(SECL_BT_BAD) |=> s_abort)
		else $error("invalid block type accepted");
	chk_nack_abort: assert property (nack_ev |=> flg_r.nack && halt_r
		&& txn_r == SECL_TS_STOP) else $error("nack did not abort");
endmodule

// file: tb/secl_ee_model.sv
// Serial memory on the master bus, one random read per transfer
module secl_ee_model (
	// Wire levels after the pull-ups
	input wire logic scl,
	input wire logic sda,
	// Refuse the device address when high
	input wire logic nack_en,
	// High pulls the data line low
	output logic drv
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535];
	logic [7:0] b;
	logic [7:0] hi;
	logic [7:0] lo;
	int n_reads = 0;
	int seq_err = 0;
	initial drv = 1'b0;

	// Shift in eight bits on rising clock
	task automatic get8(output logic [7:0] v);
		repeat (8) begin
			@(posedge scl);
			v = {v[6:0], sda};
		end
	endtask

	// Acknowledge slot, line released after it
	task automatic ack(input logic ok);
		@(negedge scl);
		drv = ok;
		@(negedge scl);
		drv = 1'b0;
	endtask

	// A stop ends any transfer, a broken one too
	always @(posedge sda) begin
		if (scl) begin
			drv = 1'b0;
			disable txn;
		end
	end

	// Address phase, repeated start, one byte out
	initial forever begin : txn
		@(negedge sda iff scl);
		get8(b);
		ack(b == 8'hA0 && !nack_en);
		get8(hi);
		ack(1'b1);
		get8(lo);
		ack(1'b1);
		@(negedge sda iff scl);
		get8(b);
		// Acknowledge, then hand the line straight to the first data bit
		@(negedge scl);
		drv = (b == 8'hA1);
		@(negedge scl);
		if ({hi, lo} != n_reads[15:0]) seq_err++;
		n_reads++;
		for (int i = 7; i >= 0; i--) begin
			drv = !mem[{hi, lo}][i];
			@(negedge scl);
		end
		drv = 1'b0;
	end
endmodule

// file: tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import secl_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic hot_reset_req = 0;
	logic tb_hold = 0;
	logic nack_en = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [2:0] switch_mode_select = 3'h2;
	logic pready, pslverr, err, ee_drv, smb_clk_out, smb_clk_oe, smb_dat_out, smb_dat_oe;
	logic load_done_flag, reset_halt_flag, load_busy;
	secl_cfg_wr_t cfg_wr;
	secl_cfg_wr_t e;
	secl_cfg_wr_t exp_q[$];
	logic [7:0] img[$];
	int err_count = 0;
	int n_checks = 0;
	// Open drain: any party pulling wins over the pull-up
	wire logic scl = ~smb_clk_oe;
	wire logic sda = ~(smb_dat_oe | ee_drv | tb_hold);
	// Top quarter of the dword space is left undefined
	wire logic cfg_unmapped = &cfg_wr.addr[15:14];

	secl_loader secl_loader_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hot_reset_req(hot_reset_req), .switch_mode_select(switch_mode_select),
		.smb_clk_in(scl), .smb_clk_out(smb_clk_out), .smb_clk_oe(smb_clk_oe),
		.smb_dat_in(sda), .smb_dat_out(smb_dat_out), .smb_dat_oe(smb_dat_oe),
		.cfg_wr(cfg_wr), .cfg_unmapped(cfg_unmapped), .load_done_flag(load_done_flag),
		.reset_halt_flag(reset_halt_flag), .load_busy(load_busy));
	secl_ee_model secl_ee_model_i (.scl(scl), .sda(sda), .nack_en(nack_en), .drv(ee_drv));

	initial forever #20 pclk = ~pclk;

	task automatic complete_run;
		if (err_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// One transfer; request held until pready is seen
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Block bytes plus the writes they must cause
	function automatic void put_blk(input logic [1:0] t, input logic [13:0] dw, input int n);
		logic [31:0] d;
		img.push_back(dw[7:0]);
		img.push_back({t, dw[13:8]});
		if (t == SECL_BT_SEQ) begin
			img.push_back(n[7:0]);
			img.push_back(n[15:8]);
		end
		for (int i = 0; i < n; i++) begin
			d = $urandom;
			for (int j = 0; j < 4; j++) img.push_back(d[8*j+:8]);
			exp_q.push_back('{1'b1, {dw + 14'(i), 2'b00}, d});
		end
	endfunction

	function automatic void put_done(input logic [7:0] bias);
		logic [7:0] s;
		s = 8'hC0;
		foreach (img[i]) s += img[i];
		img.push_back(~s + bias);
		img.push_back(8'hC0);
	endfunction

	// Mapped single, sequential run, unmapped single, then the ending
	task automatic build(input logic [1:0] last, input logic [7:0] bias);
		img.delete();
		exp_q.delete();
		put_blk(SECL_BT_SINGLE, 14'($urandom % 32'h3000), 1);
		put_blk(SECL_BT_SEQ, 14'($urandom % 32'h2000), 1 + $urandom % 3);
		put_blk(SECL_BT_SINGLE, 14'h3000 | 14'($urandom % 32'h1000), 1);
		if (last == SECL_BT_DONE) put_done(bias);
		else put_blk(last, 14'h0, 0);
	endtask

	task automatic kick(input logic [2:0] mode);
		switch_mode_select <= mode;
		repeat (4) @(posedge pclk);
		hot_reset_req <= 1'b1;
		@(posedge pclk);
		hot_reset_req <= 1'b0;
	endtask

	// Clear flags, load image, wait for the end, compare status
	task automatic run_load(input logic [2:0] md, input logic [4:0] fl, input logic h, input int nr);
		int k;
		apb(1'b1, SECL_OFF_STAT, 32'h0000_001F);
		apb(1'b1, SECL_OFF_SWITCH_CONTROL_REG, 32'h0000_0001);
		for (k = 0; k < 256; k++) secl_ee_model_i.mem[k] = 8'hFF;
		foreach (img[i]) secl_ee_model_i.mem[i] = img[i];
		secl_ee_model_i.n_reads = 0;
		secl_ee_model_i.seq_err = 0;
		kick(md);
		k = 0;
		while (load_done_flag !== 1'b1 && k < 30000) begin
			@(posedge pclk);
			k++;
		end
		apb(1'b0, SECL_OFF_STAT, 0);
		check(rd & 32'h0000_001F, {27'h0, fl}, "status");
		apb(1'b0, SECL_OFF_SWITCH_CONTROL_REG, 0);
		check(rd, {31'h0, h}, "halt");
		// Halt pin, idle busy and released bus lines after the ending
		check({28'h0, reset_halt_flag, load_busy, smb_clk_out, smb_dat_out}, {28'h0, h, 3'b011}, "pins");
		check(exp_q.size(), 0, "missing writes");
		check(secl_ee_model_i.seq_err, 0, "read order");
		if (nr >= 0) check(secl_ee_model_i.n_reads, nr, "read count");
	endtask

	// Each config write against the next expected one
	always @(posedge pclk) begin
		if (cfg_wr.en === 1'b1) begin
			e = exp_q.size() ? exp_q.pop_front() : '0;
			check({31'h0, e.en}, 1, "extra write");
			check({16'h0, cfg_wr.addr}, {16'h0, e.addr}, "cfg addr");
			check(cfg_wr.data, e.data, "cfg data");
		end
	end

	initial begin
		// About twice the longest expected run, under 100k cycles
		#3_600_000;
		err_count++;
		complete_run();
	end

	initial begin
		void'($urandom(97603));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, SECL_OFF_CTRL, 0);
		check(rd, {16'h0, SECL_PRESC_RST}, "ctrl reset");
		apb(1'b0, 8'h10, 0);
		check({31'h0, err}, 1, "bad offset");
		apb(1'b1, SECL_OFF_CTRL, 32'h0000_0002);
		kick(3'h2);
		repeat (40) @(posedge pclk);
		check({31'h0, load_busy}, 0, "no load");
		build(SECL_BT_DONE, 0);
		run_load(3'h0, 5'h11, 1'b0, img.size());
		build(SECL_BT_DONE, 1);
		run_load(3'h1, 5'h13, 1'b1, img.size());
		apb(1'b1, SECL_OFF_CTRL, 32'h0001_0002);
		build(SECL_BT_DONE, 1);
		run_load(3'h0, 5'h11, 1'b0, img.size());
		apb(1'b1, SECL_OFF_CTRL, 32'h0000_0002);
		build(SECL_BT_BAD, 0);
		run_load(3'h0, 5'h13, 1'b1, -1);
		exp_q.delete();
		nack_en <= 1'b1;
		run_load(3'h0, 5'h05, 1'b1, -1);
		nack_en <= 1'b0;
		tb_hold <= 1'b1;
		run_load(3'h0, 5'h09, 1'b1, -1);
		tb_hold <= 1'b0;
		complete_run();
	end
endmodule
